/* File: common/sfr_ext_pkg.sv */
package sfr_ext_pkg;

   // ----------------------------------------
   // direct space window
   // ----------------------------------------
   localparam logic [7:0] SFR_LOW_ADDR       = 8'h80;
   localparam logic [7:0] SFR_HIGH_ADDR      = 8'hFF;
   localparam logic [7:0] SYSTEM_CONTROL_0_ADDR = 8'h8F;

   // ----------------------------------------
   // system_control_0 layout
   // ----------------------------------------
   localparam logic [7:0] SYSCTL0_RESET      = 8'h04;
   localparam int         AREA_SELECT_BIT    = 0;
   localparam int         INT_MODE_BIT       = 4;
   localparam logic [7:0] SYSCTL0_CONST_ONES = 8'h04;

   // ----------------------------------------
   // module_bank_register layout
   // ----------------------------------------
   localparam int         BANK_LSB           = 0;
   localparam int         BANK_WIDTH         = 3;
   localparam int         SLOT_LSB           = 4;
   localparam int         OPERATION_LSB      = 6;
   localparam int         SLOT_COUNT         = 4;
   localparam logic [2:0] BANK_RESET         = 3'h0;
   localparam int         MODULE_COUNT       = 4;

   // bank register addresses (standard area), one per banked module
   localparam logic [7:0] PORT_BANK_ADDR     = 8'hB2;
   localparam logic [7:0] ADC_BANK_ADDR      = 8'hD1;
   localparam logic [7:0] CCU_BANK_ADDR      = 8'hA3;
   localparam logic [7:0] SYS_BANK_ADDR      = 8'h91;

   typedef enum logic [1:0] {
      PLAIN_WRITE0  = 2'h0,
      PLAIN_WRITE1  = 2'h1,
      SAVE_AND_LOAD = 2'h2,
      RESTORE_SLOT  = 2'h3
   } bank_operation_t;

   // ----------------------------------------
   // core access carrier
   // ----------------------------------------
   typedef struct packed {
      logic       read;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_access_t;

   // decoded target handed to peripherals
   typedef struct packed {
      logic       hit;
      logic       mapped;
      logic [7:0] offset;
      logic [2:0] bank;
   } sfr_target_t;

endpackage

/* File: hw/sfr_address_extension.sv */
`timescale 1ns/1ps
// Functional notes
// - only direct addresses 0x80..0xFF decode as register accesses
// - standard and mapped sets share the 128-address range, 256 in total
// - area select 1 routes to mapped set, 0 to standard set
// - area select is cleared only by reset or by software
// - control 0: bits 0 and 4 read/write, bit 2 reads 1, rest 0
// - each banked module's selected bank goes out on moduleBanks; the target bank field is always 0
// - bank count set per module by parameter
// - each bank register has four storage slots 0..3
// - save write copies current bank to slot and loads new bank
// - restore write loads bank from slot, ignores written bank bits
// - banking for ports, converter, capture/compare, system control
// - bank field bits 2..0; write sets bank, read returns active bank
// - bits 5..4 pick storage slot, write-only
// - operation 0X plain write, 10 save then load, 11 restore
module sfr_address_extension
   import sfr_ext_pkg::*;
#(
   parameter logic [3:0] BANK_COUNT0 = 4'd4,
   parameter logic [3:0] BANK_COUNT1 = 4'd8,
   parameter logic [3:0] BANK_COUNT2 = 4'd4,
   parameter logic [3:0] BANK_COUNT3 = 4'd2
)(
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire sfr_access_t coreAccess,
   output sfr_target_t      target,
   output logic [7:0]       readData,
   output logic             readValid,
   output logic             interruptMode,
   output logic [11:0]      moduleBanks
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // window decode
   function automatic logic inWindow(input logic [7:0] a);
      return (a >= SFR_LOW_ADDR) && (a <= SFR_HIGH_ADDR);
   endfunction

   // clamp bank to module's bank count
   function automatic logic [2:0] clampBank(input logic [2:0] b,
                                            input logic [3:0] cnt);
      return ({1'b0, b} < cnt) ? b : 3'(cnt - 4'd1);
   endfunction

   function automatic logic [7:0] bankAddr(input int m);
      case (m)
         0:       return PORT_BANK_ADDR;
         1:       return ADC_BANK_ADDR;
         2:       return CCU_BANK_ADDR;
         default: return SYS_BANK_ADDR;
      endcase
   endfunction

   function automatic logic [3:0] bankCount(input int m);
      case (m)
         0:       return BANK_COUNT0;
         1:       return BANK_COUNT1;
         2:       return BANK_COUNT2;
         default: return BANK_COUNT3;
      endcase
   endfunction

   // ----------------------------------------
   // system control 0
   // ----------------------------------------
   logic areaSelect_reg;
   logic intMode_reg;
   logic hit;
   logic ctlHit;

   assign hit    = inWindow(coreAccess.addr);
   // control 0 sits in both areas so software can always leave mapping
   assign ctlHit = hit && (coreAccess.addr == SYSTEM_CONTROL_0_ADDR);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         areaSelect_reg <= SYSCTL0_RESET[AREA_SELECT_BIT];
         intMode_reg    <= SYSCTL0_RESET[INT_MODE_BIT];
      end else if (coreAccess.write && ctlHit) begin
         areaSelect_reg <= coreAccess.wdata[AREA_SELECT_BIT];
         intMode_reg    <= coreAccess.wdata[INT_MODE_BIT];
      end
   end

   // ----------------------------------------
   // module bank registers
   // ----------------------------------------
   // ports, converter, capture/compare, system control
   logic [2:0]              bank_reg [MODULE_COUNT];
   logic [2:0]              slot_reg [MODULE_COUNT][SLOT_COUNT];
   logic [MODULE_COUNT-1:0] bankHit;
   logic [1:0]              slotSel;
   bank_operation_t         bankOp;
   logic [2:0]              newBank [MODULE_COUNT];

   always_comb begin
      for (int m = 0; m < MODULE_COUNT; m++) begin
         // bank registers live in the standard area
         bankHit[m] = hit && !areaSelect_reg &&
                      (coreAccess.addr == bankAddr(m));
      end
   end

   always_comb begin
      slotSel = coreAccess.wdata[SLOT_LSB +: 2];
      bankOp  = bank_operation_t'(coreAccess.wdata[OPERATION_LSB +: 2]);
   end

   always_comb begin
      for (int m = 0; m < MODULE_COUNT; m++) begin
         newBank[m] = clampBank(coreAccess.wdata[BANK_LSB +: BANK_WIDTH],
                                bankCount(m));
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int m = 0; m < MODULE_COUNT; m++) begin
         if (!reset_n) begin
            bank_reg[m] <= BANK_RESET;
         end else if (coreAccess.write && bankHit[m]) begin
            case (bankOp)
               SAVE_AND_LOAD: begin
                  bank_reg[m] <= newBank[m];
               end
               RESTORE_SLOT: begin
                  bank_reg[m] <= slot_reg[m][slotSel];
               end
               default: begin
                  bank_reg[m] <= newBank[m];
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int m = 0; m < MODULE_COUNT; m++) begin
         if (!reset_n) begin
            for (int s = 0; s < SLOT_COUNT; s++) begin
               slot_reg[m][s] <= BANK_RESET;
            end
         end else if (coreAccess.write && bankHit[m] &&
                      bankOp == SAVE_AND_LOAD) begin
            slot_reg[m][slotSel] <= bank_reg[m];
         end
      end
   end

   // ----------------------------------------
   // read path and routing
   // ----------------------------------------
   logic [7:0] readNext;
   always_comb begin
      readNext = 8'h00;
      if (ctlHit) begin
         readNext = SYSCTL0_CONST_ONES;
         readNext[AREA_SELECT_BIT] = areaSelect_reg;
         readNext[INT_MODE_BIT]    = intMode_reg;
      end
      for (int m = 0; m < MODULE_COUNT; m++) begin
         // read returns active bank, slot/op read zero
         if (bankHit[m])
            readNext = {5'h00, bank_reg[m]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         readData  <= 8'h00;
         readValid <= 1'b0;
      end else begin
         readData  <= readNext;
         readValid <= coreAccess.read && hit;
      end
   end

   // area routing of the decoded target
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         target <= '0;
      end else begin
         target.hit    <= hit && (coreAccess.read || coreAccess.write);
         target.mapped <= areaSelect_reg;
         target.offset <= coreAccess.addr;
         target.bank   <= 3'h0;
      end
   end

   // per-module active banks for peripheral decode
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         moduleBanks <= 12'h000;
      end else begin
         moduleBanks <= {bank_reg[3], bank_reg[2], bank_reg[1], bank_reg[0]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         interruptMode <= 1'b0;
      end else begin
         interruptMode <= intMode_reg;
      end
   end

endmodule // sfr_address_extension

/* File: sim/core_model.sv */
`timescale 1ns/1ps
module core_model
   import sfr_ext_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] readData,
   output sfr_access_t     coreAccess
);
   initial coreAccess = '0;
   // one held access per call
   task automatic acc(input logic rd, input logic [7:0] a, d);
      @(posedge sys_clk);
      coreAccess <= '{rd, !rd, a, d};
      @(posedge sys_clk);
      coreAccess <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   task automatic setArea(input logic v);
      logic [7:0] r;
      acc(1'b1, 8'h8F, 8'h00);
      #1 r = readData;
      acc(1'b0, 8'h8F, v ? (r | 8'h01) : (r & 8'hFE));
   endtask
endmodule // core_model

/* File: sim/sfr_address_extension_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin nTests++; if ((g) !== (e)) begin \
   errorCnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module sfr_address_extension_bench;
   import sfr_ext_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   sfr_access_t coreAccess;
   sfr_target_t target;
   logic [7:0]  readData;
   logic        readValid;
   logic        interruptMode;
   logic [11:0] moduleBanks;
   int          errorCnt = 0;
   int          nTests = 0;
   logic [7:0]  addrTab [4] = '{8'hB2, 8'hD1, 8'hA3, 8'h91};
   logic [7:0]  opTab [6] = '{8'h71, 8'hC7, 8'h71, 8'hA0, 8'h30, 8'hE7};
   logic [2:0]  expTab [6] = '{3'h1, 3'h0, 3'h1, 3'h0, 3'h0, 3'h1};
   always #25 sys_clk = ~sys_clk;
   core_model core_model_i (.sys_clk(sys_clk), .readData(readData),
      .coreAccess(coreAccess));
   sfr_address_extension sfr_address_extension_i (.sys_clk(sys_clk),
      .reset_n(reset_n), .coreAccess(coreAccess), .target(target),
      .readData(readData), .readValid(readValid),
      .interruptMode(interruptMode), .moduleBanks(moduleBanks));
   task automatic finalReport;
      if (errorCnt == 0 && nTests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, e);
      core_model_i.acc(1'b1, a, 8'h00);
      #1;
      `CHK("readData", e, readData)
      `CHK("readValid", 1'b1, readValid)
      `CHK("hit", 1'b1, target.hit)
      `CHK("offset", a, target.offset)
      `CHK("targetBank", 3'h0, target.bank)
   endtask
   task automatic wr(input logic [7:0] a, d);
      core_model_i.acc(1'b0, a, d);
      #1;
   endtask
   // active banks show one cycle after the write lands
   task automatic settle;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic tResetVals;
      rd(8'h8F, 8'h04);
      `CHK("banks", 12'h000, moduleBanks)
   endtask
   task automatic tControl;
      wr(8'h8F, 8'h13);
      `CHK("mapped", 1'b0, target.mapped)
      rd(8'h8F, 8'h15);
      `CHK("mapped", 1'b1, target.mapped)
      `CHK("intMode", 1'b1, interruptMode)
      wr(8'h40, 8'h00);
      `CHK("lowHit", 1'b0, target.hit)
      core_model_i.acc(1'b1, 8'h40, 8'h00);
      #1;
      `CHK("lowValid", 1'b0, readValid)
      `CHK("lowData", 8'h00, readData)
      wr(8'hB2, 8'h01);
      settle();
      `CHK("mappedBank", 3'h0, moduleBanks[2:0])
      rd(8'hB2, 8'h00);
      core_model_i.setArea(1'b0);
      rd(8'h8F, 8'h14);
   endtask
   task automatic tBanks;
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 6; k++) begin
            wr(addrTab[m], opTab[k]);
            settle();
            `CHK("bank", expTab[k], moduleBanks[3*m +: 3])
         end
         rd(addrTab[m], 8'h01);
      end
      wr(8'hB2, 8'h07);
      settle();
      `CHK("clampPort", 3'h3, moduleBanks[2:0])
      wr(8'h91, 8'h00);
      wr(8'h91, 8'h07);
      settle();
      `CHK("clampSys", 3'h1, moduleBanks[11:9])
   endtask
   task automatic tSlots;
      logic [7:0] saveOps [5] = '{8'h05, 8'h86, 8'h97, 8'hA2, 8'hB3};
      logic [7:0] backOps [4] = '{8'hF7, 8'hE0, 8'hD0, 8'hC0};
      logic [2:0] backExp [4] = '{3'h2, 3'h7, 3'h6, 3'h5};
      for (int k = 0; k < 5; k++) begin
         wr(8'hD1, saveOps[k]);
      end
      settle();
      `CHK("saveLoad", 3'h3, moduleBanks[5:3])
      wr(8'hD1, 8'h31);
      settle();
      `CHK("plainWrite", 3'h1, moduleBanks[5:3])
      for (int k = 0; k < 4; k++) begin
         wr(8'hD1, backOps[k]);
         settle();
         `CHK("restore", backExp[k], moduleBanks[5:3])
      end
   endtask
   task automatic tMidReset;
      wr(8'hB2, 8'h92);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(8'h8F, 8'h04);
      `CHK("banksReset", 12'h000, moduleBanks)
      wr(8'hB2, 8'hD5);
      settle();
      `CHK("slotReset", 3'h0, moduleBanks[2:0])
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      tResetVals();
      tControl();
      tBanks();
      tSlots();
      tMidReset();
      finalReport();
   end
   initial begin
      repeat (2000) @(posedge sys_clk);
      errorCnt++;
      finalReport();
   end
endmodule // sfr_address_extension_bench
bind sfr_address_extension sfr_ext_chk sfr_ext_chk_i (.sys_clk(sys_clk),
   .reset_n(reset_n), .coreAccess(coreAccess), .target(target),
   .readData(readData), .readValid(readValid),
   .interruptMode(interruptMode), .moduleBanks(moduleBanks));

/* File: sim/sfr_ext_chk.sv */
`timescale 1ns/1ps
module sfr_ext_chk
   import sfr_ext_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire sfr_access_t coreAccess,
   input wire sfr_target_t target,
   input wire logic [7:0]  readData,
   input wire logic        readValid,
   input wire logic        interruptMode,
   input wire logic [11:0] moduleBanks
);
   sfr_access_t ca;
   logic        areaShadow_reg;
   logic        ctlAccess;
   logic        portBankAccess;
   assign ca = coreAccess;
   assign ctlAccess = ca.addr == SYSTEM_CONTROL_0_ADDR;
   assign portBankAccess = ca.addr == PORT_BANK_ADDR && !areaShadow_reg;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         areaShadow_reg <= SYSCTL0_RESET[AREA_SELECT_BIT];
      end else if (ca.write && ctlAccess) begin
         areaShadow_reg <= ca.wdata[AREA_SELECT_BIT];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_low_miss: assert property (
      (ca.read || ca.write) && !ca.addr[7] |=>
      !target.hit && !readValid && readData == 8'h00)
      else $error("low address decoded");
   a_high_hit: assert property (
      ca.read && ca.addr[7] |=>
      target.hit && readValid && target.offset == $past(ca.addr))
      else $error("high address missed");
   a_map_route: assert property (
      (ca.read || ca.write) && ca.addr[7] |=>
      target.mapped == $past(areaShadow_reg))
      else $error("wrong area");
   a_area_keep: assert property (
      ca.read && ctlAccess |=> readData[0] == $past(areaShadow_reg))
      else $error("area select lost");
   a_ctl_fixed: assert property (
      ca.read && ctlAccess |=>
      readData[7:5] == 3'h0 && readData[3:1] == 3'h2)
      else $error("fixed bits wrong");
   a_interrupt_mode_bit_copy: assert property (
      ca.write && ctlAccess |=>
      ##1 interruptMode == $past(ca.wdata[INT_MODE_BIT], 2))
      else $error("mode bit wrong");
   a_bank_load: assert property (
      ca.write && portBankAccess && ca.wdata[7:6] != 2'h3 &&
      !ca.wdata[2] |=>
      ##1 moduleBanks[2:0] == $past(ca.wdata[2:0], 2))
      else $error("bank load wrong");
   a_bank_read: assert property (
      ca.read && portBankAccess |=>
      readData == {5'h00, moduleBanks[2:0]})
      else $error("bank read wrong");
endmodule // sfr_ext_chk
